// >>> src/conv_out_pkg.sv
/*
 * Constants, types and timing counts for the two-channel converter output control.
 * Assumes a 250 MHz control clock and a separate link clock for the output pins.
 */
// Overview of operation
// - enter nap when encode clock stops or falls below about 500 kHz.
// - stabilizer is locked only after one hundred encode cycles at a steady rate.
// - stabilizer accepts 30% to 70% encode duty and regenerates 50% internally.
// - stabilizer enable comes from clock control register, or chip-select pin level.
// - grounded negative encode input selects single-ended encode mode.
// - three output modes, picked by output control register or serial-clock pin.
// - parallel configuration offers only full rate and differential double data rate.
// - full rate drives twelve bits per channel, own overrange lines, clock pair.
// - single-ended double data rate puts two bits per line, thirteen lines fewer.
// - differential double data rate uses six data pairs per channel plus two pairs.
// - both double data rate modes share one overrange output for both channels.
// - overrange output is high when input is above or below full scale.
// - overrange flag carries the same latency as its sample word.
// - driver current resets to 3.5 mA, selectable 1.75 mA to 4.5 mA.
// - internal termination doubles the selected driver current.
// - double data rate lanes carry even bit while clock low, odd while high.
// - shared overrange shows channel two while clock low, channel one while high.
// - full rate outputs change on clock fall; double data rate on both edges.
package conv_out_pkg;

   localparam int CLK_MHZ = 250;
   localparam int NAP_FREQ_KHZ = 500;
   localparam int NAP_CYCLES = CLK_MHZ * 1000 / NAP_FREQ_KHZ;
   localparam int LOCK_EDGES = 100;
   localparam int DUTY_MIN_PCT = 30;
   localparam int DUTY_MAX_PCT = 70;
   localparam int CNT_W = 10;
   localparam int PERIOD_TOL = 1;
   localparam int DATA_W = 12;
   localparam int LANES = DATA_W / 2;
   localparam logic [2:0] CUR_RESET_CODE = 3'h4;
   localparam logic [13:0] CUR_UA_1750 = 14'h06d6;
   localparam logic [13:0] CUR_UA_2100 = 14'h0834;
   localparam logic [13:0] CUR_UA_2500 = 14'h09c4;
   localparam logic [13:0] CUR_UA_3000 = 14'h0bb8;
   localparam logic [13:0] CUR_UA_3500 = 14'h0dac;
   localparam logic [13:0] CUR_UA_4000 = 14'h0fa0;
   localparam logic [13:0] CUR_UA_4500 = 14'h1194;

   typedef enum logic [1:0] {mode_full, mode_ddr_se, mode_ddr_diff} out_mode_t;

   typedef struct packed {
      logic [DATA_W-1:0] ch1_data;
      logic ch1_or;
      logic [DATA_W-1:0] ch2_data;
      logic ch2_or;
   } sample_t;

   typedef struct packed {
      out_mode_t mode;
      logic [2:0] cur_code;
      logic term;
   } out_cfg_t;

   localparam out_cfg_t CFG_RESET = '{mode: mode_full, cur_code: CUR_RESET_CODE, term: 1'b0};

   function automatic logic [13:0] cur_ua(input logic [2:0] code);
      logic [13:0] ua;
      unique case (code)
         3'h0: ua = CUR_UA_1750;
         3'h1: ua = CUR_UA_2100;
         3'h2: ua = CUR_UA_2500;
         3'h3: ua = CUR_UA_3000;
         3'h5: ua = CUR_UA_4000;
         3'h6: ua = CUR_UA_4500;
         default: ua = CUR_UA_3500;
      endcase
      return ua;
   endfunction

endpackage

// >>> src/conv_out_ctrl.sv
/*
 * Output mode control of a two-channel 12-bit converter: encode clock watch
 * (nap, stabilizer lock and duty check) on clk, output lane formatter on link_clk.
 * Assumes samples arrive on clk with a valid strobe and that link_clk runs free.
 */
`timescale 1ns/1ps
`default_nettype none
module conv_out_ctrl (
   // clocks and reset
   input wire logic clk,
   input wire logic reset_n,
   input wire logic link_clk,
   // encode clock pins
   input wire logic encode_clock_pos,
   input wire logic encode_neg_grounded,
   // configuration pins and register fields
   input wire logic serial_config,
   input wire logic cs_pin,
   input wire logic sck_pin,
   input wire logic clock_control_register_dcs_en,
   input wire logic [1:0] output_control_register_mode,
   input wire logic [2:0] output_control_register_current,
   input wire logic output_control_register_term,
   // samples from the core
   input wire logic sample_valid,
   input var conv_out_pkg::sample_t sample_in,
   output logic sample_busy,
   // encode status
   output logic nap,
   output logic dcs_enabled,
   output logic dcs_locked,
   output logic duty_ok,
   output logic single_ended_encode,
   // link side outputs
   output logic [conv_out_pkg::DATA_W-1:0] ch1_data_bit,
   output logic [conv_out_pkg::DATA_W-1:0] ch2_data_bit,
   output logic ch1_overrange_line,
   output logic ch2_overrange_line,
   output logic [conv_out_pkg::LANES-1:0] ch1_ddr_lane,
   output logic [conv_out_pkg::LANES-1:0] ch2_ddr_lane,
   output logic shared_overrange_line,
   output logic output_clock_pos,
   output logic output_clock_neg,
   output logic lvds_drive_en,
   output logic [13:0] drive_current_ua
);
   import conv_out_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers on clk
   logic enc_s1_q, enc_s2_q, enc_s3_q;
   logic gnd_s1_q, gnd_s2_q, ser_s1_q, ser_s2_q;
   logic cs_s1_q, cs_s2_q, sck_s1_q, sck_s2_q;

   always_ff @(posedge clk) begin
      enc_s1_q <= encode_clock_pos;
      enc_s2_q <= enc_s1_q;
      enc_s3_q <= enc_s2_q;
      gnd_s1_q <= encode_neg_grounded;
      gnd_s2_q <= gnd_s1_q;
      ser_s1_q <= serial_config;
      ser_s2_q <= ser_s1_q;
      cs_s1_q <= cs_pin;
      cs_s2_q <= cs_s1_q;
      sck_s1_q <= sck_pin;
      sck_s2_q <= sck_s1_q;
   end

   wire enc_rise = enc_s2_q & ~enc_s3_q;
   wire enc_fall = ~enc_s2_q & enc_s3_q;

   ////////////////////////////////////////////////////////////////////////////
   // encode clock watch: period, high time, nap and lock
   logic [CNT_W-1:0] per_cnt_q, per_cnt_d, last_per_q, high_q;
   logic [6:0] lock_cnt_q, lock_cnt_d;
   logic nap_q, locked_q, duty_q, se_q, dcs_q;

   wire per_sat = per_cnt_q == CNT_W'(NAP_CYCLES - 1);
   wire [CNT_W:0] per_diff = {1'b0, per_cnt_q} - {1'b0, last_per_q};
   wire per_moved = (per_diff[CNT_W] ? -per_diff : per_diff) > (CNT_W + 1)'(PERIOD_TOL);
   wire [15:0] high_x100 = 16'(high_q) * 16'd100;
   wire [15:0] per_xmin = 16'(per_cnt_q) * 16'(DUTY_MIN_PCT);
   wire [15:0] per_xmax = 16'(per_cnt_q) * 16'(DUTY_MAX_PCT);
   wire duty_in = high_x100 >= per_xmin && high_x100 <= per_xmax;

   // counter saturates, so a stopped clock holds nap until edges return
   assign per_cnt_d = enc_rise ? '0 : (per_sat ? per_cnt_q : per_cnt_q + 1'b1);
   // a rate change or nap restarts the lock count
   assign lock_cnt_d = (nap_q || per_moved) ? '0 :
                       (lock_cnt_q == 7'(LOCK_EDGES) ? lock_cnt_q : lock_cnt_q + 1'b1);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         per_cnt_q <= '0;
         last_per_q <= '0;
         high_q <= '0;
         lock_cnt_q <= '0;
         nap_q <= 1'b1;
         locked_q <= 1'b0;
         duty_q <= 1'b0;
         se_q <= 1'b0;
         dcs_q <= 1'b0;
      end else begin
         per_cnt_q <= per_cnt_d;
         // duty flag drops at once when the stabilizer is switched off
         duty_q <= dcs_q && (enc_rise ? duty_in : duty_q);
         se_q <= gnd_s2_q;
         dcs_q <= ser_s2_q ? clock_control_register_dcs_en : cs_s2_q;
         if (enc_fall) begin
            high_q <= per_cnt_q;
         end
         if (per_sat && !enc_rise) begin
            nap_q <= 1'b1;
            lock_cnt_q <= '0;
            locked_q <= 1'b0;
         end else if (enc_rise) begin
            nap_q <= 1'b0;
            last_per_q <= per_cnt_q;
            lock_cnt_q <= lock_cnt_d;
            locked_q <= dcs_q && lock_cnt_d == 7'(LOCK_EDGES);
         end
      end
   end

   assign nap = nap_q;
   assign dcs_locked = locked_q;
   assign duty_ok = duty_q;
   assign single_ended_encode = se_q;
   assign dcs_enabled = dcs_q;

   ////////////////////////////////////////////////////////////////////////////
   // configuration select on clk
   out_cfg_t cfg_q, cfg_d;
   wire out_mode_t reg_mode = output_control_register_mode == 2'h3 ? mode_full
                               : out_mode_t'(output_control_register_mode);
   wire out_mode_t pin_mode = sck_s2_q ? mode_ddr_diff : mode_full;

   always_comb begin
      cfg_d = CFG_RESET;
      if (ser_s2_q) begin
         cfg_d.mode = reg_mode;
         cfg_d.cur_code = output_control_register_current;
         cfg_d.term = output_control_register_term;
      end else begin
         cfg_d.mode = pin_mode;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cfg_q <= CFG_RESET;
      end else begin
         cfg_q <= cfg_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sample handover: toggle request, held word, toggle acknowledge
   sample_t hold_q;
   logic req_q, busy_q, ack_c1_q, ack_c2_q, ack_l_q;
   wire take = sample_valid && !busy_q;

   always_ff @(posedge clk) begin
      ack_c1_q <= ack_l_q;
      ack_c2_q <= ack_c1_q;
      if (!reset_n) begin
         req_q <= 1'b0;
         busy_q <= 1'b0;
         hold_q <= '0;
      end else if (take) begin
         hold_q <= sample_in;
         req_q <= ~req_q;
         busy_q <= 1'b1;
      end else if (busy_q && ack_c2_q == req_q) begin
         busy_q <= 1'b0;
      end
   end

   assign sample_busy = busy_q;

   ////////////////////////////////////////////////////////////////////////////
   // link domain: reset, request and configuration synchronisers
   logic rst_l1_q, rst_l2_q, req_l1_q, req_l2_q;
   out_cfg_t cfg_l1_q, cfg_l2_q, cfg_l3_q;

   always_ff @(posedge link_clk) begin
      rst_l1_q <= reset_n;
      rst_l2_q <= rst_l1_q;
      req_l1_q <= req_q;
      req_l2_q <= req_l1_q;
      cfg_l1_q <= cfg_q;
      cfg_l2_q <= cfg_l1_q;
      cfg_l3_q <= cfg_l2_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain: word and setting update at the clock fall, lane packing
   sample_t word_q, word_d;
   out_cfg_t cfg_o_q, cfg_o_d;
   logic phase_q, phase_d;
   logic [LANES-1:0] lane1_d, lane2_d;

   wire boundary = phase_q; // next phase is low: a new word may start
   wire new_word = boundary && req_l2_q != ack_l_q;
   wire cfg_stable = cfg_l2_q == cfg_l3_q;
   wire ddr = cfg_o_d.mode != mode_full;

   assign phase_d = ~phase_q;
   // hold_q is stable while the request toggle is outstanding
   assign word_d = new_word ? hold_q : word_q;
   assign cfg_o_d = (boundary && cfg_stable) ? cfg_l2_q : cfg_o_q;

   for (genvar i = 0; i < LANES; i++) begin : g_lane
      assign lane1_d[i] = phase_d ? word_d.ch1_data[2*i+1] : word_d.ch1_data[2*i];
      assign lane2_d[i] = phase_d ? word_d.ch2_data[2*i+1] : word_d.ch2_data[2*i];
   end

   wire [13:0] base_ua = cur_ua(cfg_o_d.cur_code);
   wire [13:0] drive_d = cfg_o_d.term ? 14'(base_ua << 1) : base_ua;

   always_ff @(posedge link_clk) begin
      if (!rst_l2_q) begin
         phase_q <= 1'b0;
         ack_l_q <= 1'b0;
         word_q <= '0;
         cfg_o_q <= CFG_RESET;
         output_clock_pos <= 1'b0;
         output_clock_neg <= 1'b1;
         ch1_data_bit <= '0;
         ch2_data_bit <= '0;
         ch1_overrange_line <= 1'b0;
         ch2_overrange_line <= 1'b0;
         ch1_ddr_lane <= '0;
         ch2_ddr_lane <= '0;
         shared_overrange_line <= 1'b0;
         lvds_drive_en <= 1'b0;
         drive_current_ua <= CUR_UA_3500;
      end else begin
         phase_q <= phase_d;
         if (new_word) begin
            ack_l_q <= req_l2_q;
         end
         word_q <= word_d;
         cfg_o_q <= cfg_o_d;
         output_clock_pos <= phase_d;
         output_clock_neg <= ~phase_d;
         // full rate pins idle low in the double data rate modes
         ch1_data_bit <= ddr ? '0 : word_d.ch1_data;
         ch2_data_bit <= ddr ? '0 : word_d.ch2_data;
         ch1_overrange_line <= ddr ? 1'b0 : word_d.ch1_or;
         ch2_overrange_line <= ddr ? 1'b0 : word_d.ch2_or;
         ch1_ddr_lane <= ddr ? lane1_d : '0;
         ch2_ddr_lane <= ddr ? lane2_d : '0;
         shared_overrange_line <= ddr & (phase_d ? word_d.ch1_or : word_d.ch2_or);
         lvds_drive_en <= cfg_o_d.mode == mode_ddr_diff;
         drive_current_ua <= drive_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks on clk
   nap_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
      per_sat && !enc_rise |=> nap_q)
      else $error("nap not entered after encode clock loss");

   lock_count_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(locked_q) |-> lock_cnt_q == 7'(LOCK_EDGES) && !nap_q)
      else $error("stabilizer locked before one hundred cycles");

   duty_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      duty_q |-> $past(dcs_q, 1) || $past(dcs_q, 2))
      else $error("duty flagged with stabilizer off");

   dcs_source_a: assert property (@(posedge clk) disable iff (!reset_n)
      !ser_s2_q ##1 !ser_s2_q |-> dcs_q == $past(cs_s2_q))
      else $error("stabilizer enable not taken from chip-select");

   se_encode_a: assert property (@(posedge clk) disable iff (!reset_n)
      gnd_s2_q [*2] |=> se_q)
      else $error("single-ended encode not selected");

   par_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
      $past(!ser_s2_q) |-> cfg_q.mode != mode_ddr_se)
      else $error("single-ended ddr reached in parallel configuration");

   ////////////////////////////////////////////////////////////////////////////
   // checks on link_clk
   clk_pair_a: assert property (@(posedge link_clk) disable iff (!rst_l2_q)
      // the first edge out of link reset still shows the reset level
      $past(rst_l2_q) |-> output_clock_pos != $past(output_clock_pos)
         && output_clock_neg == ~output_clock_pos)
      else $error("output clock pair not toggling as complements");

   even_lane_a: assert property (@(posedge link_clk) disable iff (!rst_l2_q)
      cfg_o_q.mode != mode_full && !output_clock_pos |->
         ch1_ddr_lane[0] == word_q.ch1_data[0] && ch2_ddr_lane[LANES-1] == word_q.ch2_data[DATA_W-2])
      else $error("ddr lane not carrying the even bit while clock low");

   shared_or_a: assert property (@(posedge link_clk) disable iff (!rst_l2_q)
      cfg_o_q.mode != mode_full |->
         shared_overrange_line == (output_clock_pos ? word_q.ch1_or : word_q.ch2_or))
      else $error("shared overrange shows the wrong channel");

   full_hold_a: assert property (@(posedge link_clk) disable iff (!rst_l2_q)
      output_clock_pos && cfg_o_q.mode == mode_full && $past(cfg_o_q.mode) == mode_full
         |-> $stable(ch1_data_bit) && $stable(ch2_overrange_line))
      else $error("full rate data changed on the clock rise");

   cfg_edge_a: assert property (@(posedge link_clk) disable iff (!rst_l2_q)
      cfg_o_q != $past(cfg_o_q) |-> !output_clock_pos)
      else $error("setting applied inside a sample word");

   term_double_a: assert property (@(posedge link_clk) disable iff (!rst_l2_q)
      cfg_o_q.term |-> drive_current_ua == 14'(cur_ua(cfg_o_q.cur_code) << 1))
      else $error("termination did not double the drive current");

endmodule
`default_nettype wire

// >>> dv/lane_capture.sv
/*
 * Receiving logic model: captures the converter's link pins and rebuilds each word.
 * Assumes the pins change on rising link_clk, so it samples on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module lane_capture (
   // link clock and receiver setup
   input wire logic link_clk,
   input wire logic ddr,
   // link pins
   input wire logic [conv_out_pkg::DATA_W-1:0] ch1_data_bit,
   input wire logic [conv_out_pkg::DATA_W-1:0] ch2_data_bit,
   input wire logic ch1_overrange_line,
   input wire logic ch2_overrange_line,
   input wire logic [conv_out_pkg::LANES-1:0] ch1_ddr_lane,
   input wire logic [conv_out_pkg::LANES-1:0] ch2_ddr_lane,
   input wire logic shared_overrange_line,
   input wire logic output_clock_pos,
   input wire logic output_clock_neg,
   // rebuilt word and count of pin faults
   output conv_out_pkg::sample_t rx_word,
   output int errs
);
   import conv_out_pkg::*;
   logic [LANES-1:0] even1_q = '0;
   logic [LANES-1:0] even2_q = '0;
   logic or2_q = 1'b0;
   logic [DATA_W-1:0] full1_q = '0;
   logic [DATA_W-1:0] full2_q = '0;
   initial rx_word = '0;
   initial errs = 0;

   function automatic logic [DATA_W-1:0] weave(input logic [LANES-1:0] odd,
                                               input logic [LANES-1:0] even);
      logic [DATA_W-1:0] w;
      for (int i = 0; i < LANES; i++) begin
         w[2*i] = even[i];
         w[2*i+1] = odd[i];
      end
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // low phase holds even bits and channel two's flag, high phase the rest
   always @(negedge link_clk) begin
      if (output_clock_neg !== ~output_clock_pos)
         errs <= errs + 1;
      // an unknown clock before the link reset counts as the low phase
      if (output_clock_pos !== 1'b1) begin
         even1_q <= ch1_ddr_lane;
         even2_q <= ch2_ddr_lane;
         or2_q <= shared_overrange_line;
         full1_q <= ch1_data_bit;
         full2_q <= ch2_data_bit;
      end else if (ddr) begin
         rx_word <= {weave(ch1_ddr_lane, even1_q), shared_overrange_line,
                     weave(ch2_ddr_lane, even2_q), or2_q};
      end else begin
         // full rate words may only move at the clock fall
         if (ch1_data_bit !== full1_q || ch2_data_bit !== full2_q)
            errs <= errs + 1;
         rx_word <= {ch1_data_bit, ch1_overrange_line, ch2_data_bit, ch2_overrange_line};
      end
   end
endmodule
`default_nettype wire

// >>> dv/dual_adc_output_mode_control_tb.sv
/*
 * Self-checking bench of the converter output control, random words among corner cases.
 * Assumes the design package, the design and the lane_capture model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module dual_adc_output_mode_control_tb;
   import conv_out_pkg::*;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic reset_n = 1'b0;
   logic encode_clock_pos = 1'b0;
   logic encode_neg_grounded = 1'b0;
   logic serial_config = 1'b1;
   logic cs_pin = 1'b0;
   logic sck_pin = 1'b0;
   logic dcs_en = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [2:0] cur = 3'h4;
   logic term = 1'b0;
   logic sample_valid = 1'b0;
   sample_t sample_in = '0;
   logic rx_ddr = 1'b0;
   logic sample_busy, nap, dcs_enabled, dcs_locked, duty_ok, single_ended_encode;
   logic [DATA_W-1:0] ch1_data_bit, ch2_data_bit;
   logic ch1_overrange_line, ch2_overrange_line, shared_overrange_line;
   logic [LANES-1:0] ch1_ddr_lane, ch2_ddr_lane;
   logic output_clock_pos, output_clock_neg, lvds_drive_en;
   logic [13:0] drive_current_ua;
   sample_t rx_word;
   int rx_errs;
   int failures = 0;
   int checked = 0;
   int cycles = 0;
   int enc_cnt = 0;
   int enc_period = 20;
   int enc_high = 10;
   logic enc_run = 1'b0;
   logic [31:0] seed = 32'h6e4d0cef;
   sample_t s;

   conv_out_ctrl dut_u (.clk, .reset_n, .link_clk, .encode_clock_pos, .encode_neg_grounded,
      .serial_config, .cs_pin, .sck_pin, .clock_control_register_dcs_en(dcs_en),
      .output_control_register_mode(mode), .output_control_register_current(cur),
      .output_control_register_term(term), .sample_valid, .sample_in, .sample_busy, .nap,
      .dcs_enabled, .dcs_locked, .duty_ok, .single_ended_encode, .ch1_data_bit,
      .ch2_data_bit, .ch1_overrange_line, .ch2_overrange_line, .ch1_ddr_lane, .ch2_ddr_lane,
      .shared_overrange_line, .output_clock_pos, .output_clock_neg, .lvds_drive_en,
      .drive_current_ua);

   lane_capture rx_u (.link_clk, .ddr(rx_ddr), .ch1_data_bit, .ch2_data_bit,
      .ch1_overrange_line, .ch2_overrange_line, .ch1_ddr_lane, .ch2_ddr_lane,
      .shared_overrange_line, .output_clock_pos, .output_clock_neg, .rx_word,
      .errs(rx_errs));

   ////////////////////////////////////////////////////////////////////////////
   initial forever #2 clk = ~clk;
   // odd offset keeps the link clock out of step with clk
   initial begin
      #1.3;
      forever #3 link_clk = ~link_clk;
   end

   always @(negedge clk) begin
      enc_cnt <= (enc_cnt + 1 >= enc_period) ? 0 : enc_cnt + 1;
      encode_clock_pos <= enc_run && (enc_cnt < enc_high);
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         $display("ERROR timeout expected done seen hang");
         failures++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", name, exp, got);
         failures++;
      end
   endtask

   function automatic sample_t rnd_word();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[25:0];
   endfunction

   // driver current in uA, doubled with internal termination
   function automatic logic [31:0] cur_expect(input logic [2:0] c, input logic t);
      logic [31:0] ua;
      case (c)
         3'h0: ua = 32'd1750;
         3'h1: ua = 32'd2100;
         3'h2: ua = 32'd2500;
         3'h3: ua = 32'd3000;
         3'h5: ua = 32'd4000;
         3'h6: ua = 32'd4500;
         default: ua = 32'd3500;
      endcase
      return t ? ua * 2 : ua;
   endfunction

   task automatic link_wait(input int n);
      repeat (n) @(negedge link_clk);
      @(negedge clk);
   endtask

   task automatic wait_busy(input logic level);
      int n;
      n = 0;
      while (sample_busy !== level && n < 100) begin
         @(negedge clk);
         n++;
      end
      check("sample_busy", 32'(level), 32'(sample_busy));
   endtask

   task automatic offer(input sample_t w);
      sample_in = w;
      sample_valid = 1'b1;
      @(negedge clk);
      sample_valid = 1'b0;
   endtask

   task automatic send_chk(input sample_t w);
      offer(w);
      wait_busy(1'b1);
      wait_busy(1'b0);
      link_wait(8);
      check("rx_word", {6'h0, w}, {6'h0, rx_word});
      if (!rx_ddr) begin
         check("full_pins", {6'h0, w}, {6'h0, ch1_data_bit, ch1_overrange_line,
               ch2_data_bit, ch2_overrange_line});
         check("ddr_pins", 32'h0, {19'h0, ch1_ddr_lane, ch2_ddr_lane,
               shared_overrange_line});
      end else begin
         check("full_pins", 32'h0, {6'h0, ch1_data_bit, ch1_overrange_line, ch2_data_bit,
               ch2_overrange_line});
      end
   endtask

   task automatic set_cfg(input logic ser, input logic [1:0] md, input logic [2:0] c,
                          input logic t, input logic d);
      serial_config = ser;
      mode = md;
      cur = c;
      term = t;
      rx_ddr = d;
      link_wait(12);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(negedge clk);
      reset_n = 1'b1;
      check("nap", 32'h1, 32'(nap));
      check("current", 32'd3500, 32'(drive_current_ua));
      // code 3 falls back to full rate
      for (int m = 0; m < 4; m++) begin
         set_cfg(1'b1, 2'(m), 3'h4, 1'b0, m == 1 || m == 2);
         check("lvds_en", 32'(m == 2), 32'(lvds_drive_en));
         for (int i = 0; i < 6; i++) begin
            s = rnd_word();
            if (i == 0)
               s = '1;
            if (i == 1)
               s = '0;
            send_chk(s);
         end
      end
      // a word offered while busy is dropped, the first one stays
      s = rnd_word();
      offer(s);
      wait_busy(1'b1);
      offer(~s);
      wait_busy(1'b0);
      link_wait(8);
      check("refused", {6'h0, s}, {6'h0, rx_word});
      for (int k = 0; k < 16; k++) begin
         set_cfg(1'b1, 2'h2, 3'(k >> 1), k[0], 1'b1);
         check("current", cur_expect(3'(k >> 1), k[0]), 32'(drive_current_ua));
      end
      sck_pin = 1'b0;
      set_cfg(1'b0, 2'h1, 3'h0, 1'b1, 1'b0);
      send_chk(rnd_word());
      check("lvds_en", 32'h0, 32'(lvds_drive_en));
      sck_pin = 1'b1;
      set_cfg(1'b0, 2'h1, 3'h0, 1'b1, 1'b1);
      send_chk(rnd_word());
      check("lvds_en", 32'h1, 32'(lvds_drive_en));
      check("current", 32'd3500, 32'(drive_current_ua));
      for (int k = 0; k < 4; k++) begin
         serial_config = k[1];
         cs_pin = k[0];
         dcs_en = ~k[0];
         encode_neg_grounded = k[0];
         repeat (8) @(negedge clk);
         check("dcs_enabled", 32'(k[1] ? !k[0] : k[0]), 32'(dcs_enabled));
         check("se_encode", 32'(k[0]), 32'(single_ended_encode));
      end
      dcs_en = 1'b1;
      enc_run = 1'b1;
      repeat (1200) @(negedge clk);
      check("nap", 32'h0, 32'(nap));
      check("locked", 32'h0, 32'(dcs_locked));
      repeat (1300) @(negedge clk);
      check("locked", 32'h1, 32'(dcs_locked));
      check("duty_ok", 32'h1, 32'(duty_ok));
      enc_period = 30;
      enc_high = 12;
      repeat (1200) @(negedge clk);
      check("locked", 32'h0, 32'(dcs_locked));
      repeat (2700) @(negedge clk);
      check("locked", 32'h1, 32'(dcs_locked));
      check("duty_ok", 32'h1, 32'(duty_ok));
      enc_high = 6;
      repeat (150) @(negedge clk);
      check("duty_ok", 32'h0, 32'(duty_ok));
      enc_high = 24;
      repeat (150) @(negedge clk);
      check("duty_ok", 32'h0, 32'(duty_ok));
      enc_run = 1'b0;
      repeat (400) @(negedge clk);
      check("nap", 32'h0, 32'(nap));
      repeat (150) @(negedge clk);
      check("nap", 32'h1, 32'(nap));
      check("rx_errs", 32'h0, 32'(rx_errs));
      complete_run();
   end
endmodule
`default_nettype wire
